/* hw/rha_defines.svh */
// Constants of the radio host API framing ends
`ifndef RHA_DEFINES_SVH
`define RHA_DEFINES_SVH

`define RHA_CFG_ADDR        8'hc1
`define RHA_RETRY_ADDR      8'h4c
`define RHA_CFG_RST         8'h00
`define RHA_RETRY_RST       8'h03
`define RHA_BIT_RX          0
`define RHA_BIT_TX          1
`define RHA_BIT_SDC         2
`define RHA_BCAST_ADDR      24'hffffff
`define RHA_HDR_RX          8'h81
`define RHA_HDR_SDC         8'h82
`define RHA_SDC_OK          8'h00
`define RHA_SDC_FAIL        8'h01
`define RHA_RX_HDR_LAST     3'h4
`define RHA_DEST_BYTES      2'h3
`define RHA_CLK_PERIOD_NS   5
`define RHA_ACK_WAIT_NS     20000
`define RHA_MAX_LEN         239

`define RHA_REG_TX          8'h00
`define RHA_REG_RX          8'h04
`define RHA_REG_STAT        8'h08
`define RHA_REG_MASK        8'h0c
`define RHA_REG_DEV_ADDR    8'h10
`define RHA_REG_DEV_DATA    8'h14
`define RHA_REG_DEV_RD      8'h18
`define RHA_REG_DEST        8'h1c
`define RHA_ST_RX           0
`define RHA_ST_OK           1
`define RHA_ST_FAIL         2
`define RHA_ST_TXD          3
`define RHA_TX_LAST_BIT     8

`endif

/* hw/rha_dev.sv */
// Radio device end: config bytes, transmit with retries, receive framing
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "rha_defines.svh"
`default_nettype none
module rha_dev #(
  parameter int          MAX_LEN  = `RHA_MAX_LEN,
  parameter int          ACK_WAIT = `RHA_ACK_WAIT_NS / `RHA_CLK_PERIOD_NS,
  parameter logic [23:0] DEF_DEST = `RHA_BCAST_ADDR
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  rha_link_if.dev          lk,
  output logic             RF_TX_VALID,
  output logic [7:0]       RF_TX_DATA,
  output logic             RF_TX_LAST,
  output logic [23:0]      RF_TX_DEST,
  output logic             RF_TX_BCAST,
  input  wire logic        RF_TX_READY,
  input  wire logic        RF_ACK,
  input  wire logic        RF_RX_VALID,
  input  wire logic [7:0]  RF_RX_DATA,
  input  wire logic        RF_RX_LAST,
  input  wire logic [23:0] RF_RX_SRC,
  input  wire logic [7:0]  RF_RX_RSSI,
  output logic             RF_RX_READY
);
  if (MAX_LEN < 1 || MAX_LEN > 255) begin : g_bad_len
    $error("MAX_LEN must lie in 1..255");
  end
  if (ACK_WAIT < 1 || ACK_WAIT > 65535) begin : g_bad_wait
    $error("ACK_WAIT must lie in 1..65535");
  end

  typedef struct packed {
    rha_pkg::rha_tx_st_t  tx_st;
    rha_pkg::rha_d2h_st_t d_st;
    logic [7:0]           cfg;
    logic [7:0]           retries;
    logic [7:0]           cfg_rdata;
    logic                 h2d_ready;
    logic [1:0]           hdr_cnt;
    logic [7:0]           wr_idx;
    logic [7:0]           len;
    logic [23:0]          dest;
    logic [7:0]           rd_idx;
    logic [7:0]           attempts;
    logic [15:0]          wait_cnt;
    logic                 rf_tx_valid;
    logic [7:0]           rf_tx_data;
    logic                 rf_tx_last;
    logic                 rf_tx_bcast;
    logic                 sdc_pend;
    logic                 sdc_ok;
    logic                 d2h_valid;
    logic [7:0]           d2h_data;
    logic                 d2h_last;
    logic [2:0]           rx_idx;
    logic                 rx_ready;
    logic [23:0]          rx_src;
    logic [7:0]           rx_rssi;
  } rha_dev_st_t;

  rha_dev_st_t st_ff;
  rha_dev_st_t nxt_st;
  logic [7:0]  mem [MAX_LEN];
  logic        mem_we;
  logic [7:0]  mem_wa;
  logic        h2d_take;
  logic        rx_take;

  function automatic logic [7:0] src_byte(input logic [23:0] src, input logic [2:0] idx);
    case (idx)
      3'h1:    src_byte = src[23:16];
      3'h2:    src_byte = src[15:8];
      default: src_byte = src[7:0];
    endcase
  endfunction

  always_comb begin
    nxt_st   = st_ff;
    mem_we   = 1'b0;
    mem_wa   = st_ff.wr_idx;
    h2d_take = lk.h2d_valid && st_ff.h2d_ready;
    rx_take  = RF_RX_VALID && st_ff.rx_ready;

    // Config port; read data stands until the next read
    if (lk.cfg_wr) begin
      if (lk.cfg_addr == `RHA_CFG_ADDR) begin
        nxt_st.cfg = lk.cfg_wdata;
      end
      if (lk.cfg_addr == `RHA_RETRY_ADDR && lk.cfg_wdata != 8'h00) begin
        nxt_st.retries = lk.cfg_wdata;
      end
    end
    if (lk.cfg_rd) begin
      case (lk.cfg_addr)
        `RHA_CFG_ADDR:   nxt_st.cfg_rdata = st_ff.cfg;
        `RHA_RETRY_ADDR: nxt_st.cfg_rdata = st_ff.retries;
        default:         nxt_st.cfg_rdata = 8'h00;
      endcase
    end

    // Device to host byte stream
    if (st_ff.d2h_valid && lk.d2h_ready) begin
      nxt_st.d2h_valid = 1'b0;
    end
    case (st_ff.d_st)
      rha_pkg::D_IDLE: begin
        if (st_ff.sdc_pend) begin
          nxt_st.sdc_pend  = 1'b0;
          nxt_st.d2h_valid = 1'b1;
          nxt_st.d2h_data  = `RHA_HDR_SDC;
          nxt_st.d2h_last  = 1'b0;
          nxt_st.d_st      = rha_pkg::D_SDC;
        end else if (RF_RX_VALID && st_ff.cfg[`RHA_BIT_RX]) begin
          nxt_st.rx_src    = RF_RX_SRC;
          nxt_st.rx_rssi   = RF_RX_RSSI;
          nxt_st.rx_idx    = 3'h1;
          nxt_st.d2h_valid = 1'b1;
          nxt_st.d2h_data  = `RHA_HDR_RX;
          nxt_st.d2h_last  = 1'b0;
          nxt_st.d_st      = rha_pkg::D_HDR;
        end else if (RF_RX_VALID) begin
          nxt_st.d_st = rha_pkg::D_PAY;
        end
      end
      rha_pkg::D_HDR: begin
        if (!nxt_st.d2h_valid) begin
          nxt_st.d2h_valid = 1'b1;
          nxt_st.rx_idx    = st_ff.rx_idx + 3'h1;
          if (st_ff.rx_idx == `RHA_RX_HDR_LAST) begin
            nxt_st.d2h_data = st_ff.rx_rssi;
            nxt_st.d_st     = rha_pkg::D_PAY;
          end else begin
            nxt_st.d2h_data = src_byte(st_ff.rx_src, st_ff.rx_idx);
          end
        end
      end
      rha_pkg::D_PAY: begin
        if (rx_take) begin
          nxt_st.d2h_valid = 1'b1;
          nxt_st.d2h_data  = RF_RX_DATA;
          nxt_st.d2h_last  = RF_RX_LAST;
          if (RF_RX_LAST) begin
            nxt_st.d_st = rha_pkg::D_END;
          end
        end
      end
      rha_pkg::D_SDC: begin
        if (!nxt_st.d2h_valid) begin
          nxt_st.d2h_valid = 1'b1;
          nxt_st.d2h_data  = st_ff.sdc_ok ? `RHA_SDC_OK : `RHA_SDC_FAIL;
          nxt_st.d2h_last  = 1'b1;
          nxt_st.d_st      = rha_pkg::D_END;
        end
      end
      rha_pkg::D_END: begin
        if (!nxt_st.d2h_valid) begin
          nxt_st.d_st = rha_pkg::D_IDLE;
        end
      end
      default: nxt_st.d_st = rha_pkg::D_IDLE;
    endcase
    // Registered ready only opens with an empty output byte, halving rate
    nxt_st.rx_ready = (nxt_st.d_st == rha_pkg::D_PAY) && !nxt_st.d2h_valid;

    // Host to radio transmit path
    case (st_ff.tx_st)
      rha_pkg::T_IDLE: begin
        nxt_st.wr_idx = 8'h00;
        if (h2d_take && st_ff.cfg[`RHA_BIT_TX]) begin
          nxt_st.dest    = {st_ff.dest[15:0], lk.h2d_data};
          nxt_st.hdr_cnt = 2'h1;
          nxt_st.tx_st   = lk.h2d_last ? rha_pkg::T_IDLE : rha_pkg::T_DEST;
        end else if (h2d_take) begin
          nxt_st.dest   = DEF_DEST;
          mem_we        = 1'b1;
          // Index may still hold the last packet's length on the first idle cycle
          mem_wa        = 8'h00;
          nxt_st.wr_idx = 8'h01;
          nxt_st.len    = 8'h01;
          nxt_st.tx_st  = lk.h2d_last || MAX_LEN == 1 ? rha_pkg::T_SEND : rha_pkg::T_LOAD;
        end
      end
      rha_pkg::T_DEST: begin
        if (h2d_take) begin
          nxt_st.dest    = {st_ff.dest[15:0], lk.h2d_data};
          nxt_st.hdr_cnt = st_ff.hdr_cnt + 2'h1;
          if (lk.h2d_last) begin
            nxt_st.tx_st = rha_pkg::T_IDLE;
          end else if (st_ff.hdr_cnt == `RHA_DEST_BYTES - 2'h1) begin
            nxt_st.tx_st = rha_pkg::T_LOAD;
          end
        end
      end
      rha_pkg::T_LOAD: begin
        if (h2d_take) begin
          mem_we        = 1'b1;
          nxt_st.wr_idx = st_ff.wr_idx + 8'h01;
          nxt_st.len    = st_ff.wr_idx + 8'h01;
          // A packet longer than the buffer is cut; the rest starts a new one
          if (lk.h2d_last || st_ff.wr_idx == 8'(MAX_LEN - 1)) begin
            nxt_st.tx_st = rha_pkg::T_SEND;
          end
        end
      end
      rha_pkg::T_SEND: begin
        nxt_st.rf_tx_bcast = (st_ff.dest == `RHA_BCAST_ADDR);
        if (!st_ff.rf_tx_valid || RF_TX_READY) begin
          if (st_ff.rd_idx == st_ff.len) begin
            nxt_st.rf_tx_valid = 1'b0;
            nxt_st.rd_idx      = 8'h00;
            nxt_st.wait_cnt    = 16'h0000;
            nxt_st.attempts    = st_ff.attempts + 8'h01;
            nxt_st.tx_st = nxt_st.rf_tx_bcast ? rha_pkg::T_IDLE : rha_pkg::T_WAIT;
          end else begin
            nxt_st.rf_tx_valid = 1'b1;
            nxt_st.rf_tx_data  = mem[st_ff.rd_idx];
            nxt_st.rf_tx_last  = (st_ff.rd_idx == st_ff.len - 8'h01);
            nxt_st.rd_idx      = st_ff.rd_idx + 8'h01;
          end
        end
      end
      rha_pkg::T_WAIT: begin
        nxt_st.wait_cnt = st_ff.wait_cnt + 16'h0001;
        if (RF_ACK) begin
          nxt_st.sdc_ok = 1'b1;
          nxt_st.tx_st  = rha_pkg::T_DONE;
        end else if (st_ff.wait_cnt == 16'(ACK_WAIT - 1)) begin
          if (st_ff.attempts >= st_ff.retries) begin
            nxt_st.sdc_ok = 1'b0;
            nxt_st.tx_st  = rha_pkg::T_DONE;
          end else begin
            nxt_st.tx_st = rha_pkg::T_SEND;
          end
        end
      end
      rha_pkg::T_DONE: begin
        // Waits for any earlier report so none is lost
        if (!st_ff.sdc_pend) begin
          nxt_st.sdc_pend = st_ff.cfg[`RHA_BIT_SDC];
          nxt_st.attempts = 8'h00;
          nxt_st.tx_st    = rha_pkg::T_IDLE;
        end
      end
      default: nxt_st.tx_st = rha_pkg::T_IDLE;
    endcase
    if (nxt_st.tx_st == rha_pkg::T_IDLE) begin
      nxt_st.attempts = 8'h00;
    end
    nxt_st.h2d_ready = (nxt_st.tx_st == rha_pkg::T_IDLE) || (nxt_st.tx_st == rha_pkg::T_DEST)
                       || (nxt_st.tx_st == rha_pkg::T_LOAD);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff         <= '0;
      st_ff.tx_st   <= rha_pkg::T_IDLE;
      st_ff.d_st    <= rha_pkg::D_IDLE;
      st_ff.cfg     <= `RHA_CFG_RST;
      st_ff.retries <= `RHA_RETRY_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Payload is kept for resends, so it has no reset
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= lk.h2d_data;
    end
  end

  assign lk.h2d_ready  = st_ff.h2d_ready;
  assign lk.d2h_valid  = st_ff.d2h_valid;
  assign lk.d2h_data   = st_ff.d2h_data;
  assign lk.d2h_last   = st_ff.d2h_last;
  assign lk.cfg_rdata  = st_ff.cfg_rdata;
  assign RF_TX_VALID   = st_ff.rf_tx_valid;
  assign RF_TX_DATA    = st_ff.rf_tx_data;
  assign RF_TX_LAST    = st_ff.rf_tx_last;
  assign RF_TX_DEST    = st_ff.dest;
  assign RF_TX_BCAST   = st_ff.rf_tx_bcast;
  assign RF_RX_READY   = st_ff.rx_ready;
endmodule
`default_nettype wire

/* hw/rha_host.sv */
// Host controller end: software registers, header insertion, report capture
`timescale 1ns/10ps
`include "rha_defines.svh"
`default_nettype none
module rha_host (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             IRQ,
  rha_link_if.hst          lk
);
  typedef struct packed {
    logic        h2d_valid;
    logic [7:0]  h2d_data;
    logic        h2d_last;
    logic [1:0]  hdr_cnt;
    logic [23:0] dest;
    logic [7:0]  pay_data;
    logic        pay_last;
    logic        pay_held;
    logic        tx_start;
    logic        cfg_wr;
    logic        cfg_rd;
    logic [7:0]  cfg_addr;
    logic [7:0]  cfg_wdata;
    logic [7:0]  api_shadow;
    logic        rd_pend;
    logic [7:0]  dev_rdata;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_last;
    logic        d2h_ready;
    logic        in_frame;
    logic        sdc_next;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        irq;
  } rha_host_st_t;

  rha_host_st_t st_ff;
  rha_host_st_t nxt_st;
  logic [3:0]   set_bits;
  logic         busy;

  always_comb begin
    nxt_st          = st_ff;
    set_bits        = 4'h0;
    busy            = st_ff.h2d_valid || st_ff.pay_held || st_ff.hdr_cnt != 2'h0;
    nxt_st.cfg_wr   = 1'b0;
    nxt_st.cfg_rd   = 1'b0;
    nxt_st.rdata    = 32'h0000_0000;
    nxt_st.rd_pend  = st_ff.cfg_rd;
    if (st_ff.rd_pend) begin
      nxt_st.dev_rdata = lk.cfg_rdata;
    end

    if (WR) begin
      case (ADDR)
        `RHA_REG_TX: begin
          // A write while busy is dropped; software polls the busy bit
          if (!busy) begin
            nxt_st.pay_data = WDATA[7:0];
            nxt_st.pay_last = WDATA[`RHA_TX_LAST_BIT];
            nxt_st.pay_held = 1'b1;
            nxt_st.tx_start = WDATA[`RHA_TX_LAST_BIT];
            if (st_ff.tx_start && st_ff.api_shadow[`RHA_BIT_TX]) begin
              nxt_st.hdr_cnt = `RHA_DEST_BYTES;
            end
          end
        end
        `RHA_REG_MASK:     nxt_st.mask     = WDATA[3:0];
        `RHA_REG_DEST:     nxt_st.dest     = WDATA[23:0];
        `RHA_REG_DEV_ADDR: nxt_st.cfg_addr = WDATA[7:0];
        `RHA_REG_DEV_DATA: begin
          nxt_st.cfg_wr    = 1'b1;
          nxt_st.cfg_wdata = WDATA[7:0];
          if (st_ff.cfg_addr == `RHA_CFG_ADDR) begin
            nxt_st.api_shadow = WDATA[7:0];
          end
        end
        `RHA_REG_DEV_RD:   nxt_st.cfg_rd   = 1'b1;
        default: ;
      endcase
    end

    // Outgoing bytes: destination header first, most significant byte first
    if (st_ff.h2d_valid && lk.h2d_ready) begin
      nxt_st.h2d_valid = 1'b0;
      if (st_ff.h2d_last) begin
        set_bits[`RHA_ST_TXD] = 1'b1;
      end
    end
    if (!nxt_st.h2d_valid && nxt_st.hdr_cnt != 2'h0) begin
      nxt_st.h2d_valid = 1'b1;
      nxt_st.h2d_last  = 1'b0;
      // Byte is picked from the count before it steps down
      case (nxt_st.hdr_cnt)
        2'h3:    nxt_st.h2d_data = st_ff.dest[23:16];
        2'h2:    nxt_st.h2d_data = st_ff.dest[15:8];
        default: nxt_st.h2d_data = st_ff.dest[7:0];
      endcase
      nxt_st.hdr_cnt   = nxt_st.hdr_cnt - 2'h1;
    end else if (!nxt_st.h2d_valid && nxt_st.pay_held) begin
      nxt_st.h2d_valid = 1'b1;
      nxt_st.h2d_data  = nxt_st.pay_data;
      nxt_st.h2d_last  = nxt_st.pay_last;
      nxt_st.pay_held  = 1'b0;
    end

    // Incoming bytes: completion reports are consumed here
    if (RD && ADDR == `RHA_REG_RX) begin
      nxt_st.rx_valid = 1'b0;
    end
    if (lk.d2h_valid && st_ff.d2h_ready) begin
      nxt_st.in_frame = !lk.d2h_last;
      if (!st_ff.in_frame && lk.d2h_data == `RHA_HDR_SDC && st_ff.api_shadow[`RHA_BIT_SDC]) begin
        nxt_st.sdc_next = 1'b1;
      end else if (st_ff.sdc_next) begin
        nxt_st.sdc_next = 1'b0;
        // Failure raises its own flag so software can resubmit the payload
        if (lk.d2h_data == `RHA_SDC_OK) begin
          set_bits[`RHA_ST_OK] = 1'b1;
        end else begin
          set_bits[`RHA_ST_FAIL] = 1'b1;
        end
      end else begin
        nxt_st.rx_valid      = 1'b1;
        nxt_st.rx_data       = lk.d2h_data;
        nxt_st.rx_last       = lk.d2h_last;
        set_bits[`RHA_ST_RX] = 1'b1;
      end
    end
    nxt_st.d2h_ready = !nxt_st.rx_valid;

    if (RD) begin
      case (ADDR)
        `RHA_REG_RX:       nxt_st.rdata = {22'h0, st_ff.rx_valid, st_ff.rx_last, st_ff.rx_data};
        `RHA_REG_STAT:     nxt_st.rdata = {23'h0, busy, 4'h0, st_ff.status};
        `RHA_REG_MASK:     nxt_st.rdata = {28'h0, st_ff.mask};
        `RHA_REG_DEV_DATA: nxt_st.rdata = {24'h0, st_ff.dev_rdata};
        `RHA_REG_DEST:     nxt_st.rdata = {8'h0, st_ff.dest};
        default:           nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Set wins over the read-clear of the same cycle
    nxt_st.status = ((RD && ADDR == `RHA_REG_STAT) ? 4'h0 : st_ff.status) | set_bits;
    nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff            <= '0;
      st_ff.tx_start   <= 1'b1;
      st_ff.d2h_ready  <= 1'b1;
      st_ff.dest       <= `RHA_BCAST_ADDR;
      st_ff.api_shadow <= `RHA_CFG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lk.h2d_valid = st_ff.h2d_valid;
  assign lk.h2d_data  = st_ff.h2d_data;
  assign lk.h2d_last  = st_ff.h2d_last;
  assign lk.d2h_ready = st_ff.d2h_ready;
  assign lk.cfg_wr    = st_ff.cfg_wr;
  assign lk.cfg_rd    = st_ff.cfg_rd;
  assign lk.cfg_addr  = st_ff.cfg_addr;
  assign lk.cfg_wdata = st_ff.cfg_wdata;
  assign RDATA        = st_ff.rdata;
  assign IRQ          = st_ff.irq;
endmodule
`default_nettype wire

/* hw/rha_link_if.sv */
// Byte link and config port between host controller and radio device
`timescale 1ns/10ps
`default_nettype none
interface rha_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_last;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_last;
  logic       d2h_ready;
  logic       cfg_wr;
  logic       cfg_rd;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;

  modport dev (input h2d_data, h2d_valid, h2d_last, d2h_ready, cfg_wr, cfg_rd, cfg_addr,
               cfg_wdata, output h2d_ready, d2h_data, d2h_valid, d2h_last, cfg_rdata);
  modport hst (output h2d_data, h2d_valid, h2d_last, d2h_ready, cfg_wr, cfg_rd, cfg_addr,
               cfg_wdata, input h2d_ready, d2h_data, d2h_valid, d2h_last, cfg_rdata);
endinterface
`default_nettype wire

/* hw/rha_pkg.sv */
// State types of the device end of the radio host API framing
package rha_pkg;
  typedef enum logic [5:0] {
    T_IDLE = 6'h01,
    T_DEST = 6'h02,
    T_LOAD = 6'h04,
    T_SEND = 6'h08,
    T_WAIT = 6'h10,
    T_DONE = 6'h20
  } rha_tx_st_t;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_HDR  = 5'h02,
    D_PAY  = 5'h04,
    D_SDC  = 5'h08,
    D_END  = 5'h10
  } rha_d2h_st_t;
endpackage

/* testbench/rha_link_assertions.sv */
// Checker of the byte link and config port between the two ends
`timescale 1ns/10ps
`default_nettype none
module rha_link_assertions (
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_last,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_last,
  input wire logic       d2h_ready,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  logic       sof_ff, rep_ff, rxf_ff, rxh;
  logic [7:0] cnt_ff, cfg_ff, rty_ff;
  // Shadows follow config writes, so frame checks know which features are on
  assign rxh = sof_ff && cfg_ff[0] && d2h_data == 8'h81;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sof_ff <= 1'b1;
      rep_ff <= 1'b0;
      rxf_ff <= 1'b0;
      cnt_ff <= 8'h00;
      cfg_ff <= 8'h00;
      rty_ff <= 8'h03;
    end else begin
      if (cfg_wr && cfg_addr == 8'hc1) cfg_ff <= cfg_wdata;
      if (cfg_wr && cfg_addr == 8'h4c && cfg_wdata != 8'h00) rty_ff <= cfg_wdata;
      if (d2h_valid && d2h_ready) begin
        sof_ff <= d2h_last;
        cnt_ff <= d2h_last ? 8'h00 : cnt_ff + 8'h01;
        rep_ff <= sof_ff && cfg_ff[2] && d2h_data == 8'h82;
        rxf_ff <= !d2h_last && (rxh || rxf_ff);
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_cfg_excl: assert property (!(cfg_wr && cfg_rd)) else $error("cfg wr and rd");
  a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("rdata moved");
  a_cfg_read: assert property (cfg_rd && cfg_addr == 8'hc1 |=> cfg_rdata == cfg_ff)
    else $error("config byte wrong");
  a_rty_read: assert property (cfg_rd && cfg_addr == 8'h4c |=> cfg_rdata == rty_ff)
    else $error("retry byte wrong");
  a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid
    && $stable(h2d_data) && $stable(h2d_last)) else $error("h2d dropped");
  a_d2h_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid
    && $stable(d2h_data) && $stable(d2h_last)) else $error("d2h dropped");
  a_h2d_busy: assert property (h2d_valid && h2d_ready && h2d_last |=> !h2d_ready)
    else $error("ready after packet");
  a_sdc_len: assert property (cfg_ff[2] && sof_ff && d2h_valid && d2h_data == 8'h82
    |-> !d2h_last) else $error("report too short");
  a_sdc_code: assert property (rep_ff && d2h_valid
    |-> d2h_last && d2h_data inside {8'h00, 8'h01}) else $error("report code bad");
  a_rx_start: assert property (sof_ff && d2h_valid && cfg_ff[0]
    && !(cfg_ff[2] && d2h_data == 8'h82) |-> d2h_data == 8'h81) else $error("rx frame header");
  a_rx_hdr_len: assert property ((rxh || rxf_ff) && d2h_valid && d2h_last
    |-> cnt_ff >= 8'h05) else $error("rx frame short");
  c_sdc: cover property (rep_ff && d2h_valid && d2h_ready);
  c_rx: cover property (rxf_ff && d2h_valid && d2h_ready && d2h_last);
  c_pkt: cover property (h2d_valid && h2d_ready && h2d_last);
endmodule
`default_nettype wire

/* testbench/test_radio_host_api_framing.sv */
// Testbench of the host and device ends joined by the byte link
`timescale 1ns/10ps
`include "rha_defines.svh"
`default_nettype none
module test_radio_host_api_framing;
  logic        clk, arst_n, wr, rd, irq, ack, ack_d, ack_en, tv, tl, tb, bc, rv, rl, rr;
  logic [7:0]  addr, td, rdt, rs;
  logic [23:0] tdst, dst, src;
  logic [31:0] wdata, rdata, v, acc;
  logic [8:0]  rq[$];
  logic [7:0]  tq[$];
  logic [7:0]  ex[7] = '{8'h81, 8'ha1, 8'hb2, 8'hc3, 8'h5d, 8'h40, 8'h41};
  int          errors, check_count, tn;
  rha_link_if lk ();
  rha_host rha_host_i (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ(irq), .lk(lk.hst));
  rha_dev #(.ACK_WAIT(8)) rha_dev_i (.CLK(clk), .ARST_N(arst_n), .lk(lk.dev), .RF_TX_VALID(tv),
    .RF_TX_DATA(td), .RF_TX_LAST(tl), .RF_TX_DEST(tdst), .RF_TX_BCAST(tb), .RF_TX_READY(1'b1),
    .RF_ACK(ack), .RF_RX_VALID(rv), .RF_RX_DATA(rdt), .RF_RX_LAST(rl), .RF_RX_SRC(src),
    .RF_RX_RSSI(rs), .RF_RX_READY(rr));
  rha_link_assertions rha_link_assertions_i (.CLK(clk), .ARST_N(arst_n),
    .h2d_data(lk.h2d_data), .h2d_valid(lk.h2d_valid), .h2d_last(lk.h2d_last),
    .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data), .d2h_valid(lk.d2h_valid),
    .d2h_last(lk.d2h_last), .d2h_ready(lk.d2h_ready), .cfg_wr(lk.cfg_wr), .cfg_rd(lk.cfg_rd),
    .cfg_addr(lk.cfg_addr), .cfg_wdata(lk.cfg_wdata), .cfg_rdata(lk.cfg_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Radio side: every byte on air is logged, an ack can follow each packet
  always @(posedge clk) begin
    if (tv) tq.push_back(td);
    if (tv && tl) begin
      tn++;
      dst = tdst;
      bc = tb;
    end
    ack_d <= ack_en && tv && tl;
    ack <= ack_d;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task hang();
    errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    stop_test();
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Status reads clear the sticky bits, so every status read is folded into acc
  task rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    if (a == `RHA_REG_STAT) acc |= v;
  endtask
  task dwr(input logic [7:0] a, input logic [7:0] d);
    wrr(`RHA_REG_DEV_ADDR, {24'h0, a});
    wrr(`RHA_REG_DEV_DATA, {24'h0, d});
  endtask
  task drd(input logic [7:0] a);
    wrr(`RHA_REG_DEV_ADDR, {24'h0, a});
    wrr(`RHA_REG_DEV_RD, 32'h0);
    repeat (3) @(posedge clk);
    rdr(`RHA_REG_DEV_DATA);
  endtask
  // A TX write while busy is dropped, so busy is waited out first
  task txb(input logic [8:0] w);
    for (int i = 0; i < 500; i++) begin
      rdr(`RHA_REG_STAT);
      if (v[8] === 1'b0) break;
    end
    if (v[8] !== 1'b0) hang();
    wrr(`RHA_REG_TX, {23'h0, w});
  endtask
  task wtx(input int n);
    for (int i = 0; i < 500 && tn < n; i++) @(posedge clk);
    if (tn < n) hang();
  endtask
  task rfrx(input int n);
    int j;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rv <= 1'b1;
      rdt <= 8'h40 + i[7:0];
      rl <= (i == n - 1);
      j = 0;
      do begin
        @(posedge clk);
        j++;
      end while (rr !== 1'b1 && j < 200);
      if (rr !== 1'b1) hang();
      rv <= 1'b0;
      rdt <= ~rdt;
    end
  endtask
  task rxget(input int n);
    rq.delete();
    for (int i = 0; i < 400 && rq.size() < n; i++) begin
      rdr(`RHA_REG_RX);
      if (v[9] === 1'b1) rq.push_back(v[8:0]);
    end
    if (rq.size() < n) hang();
  endtask
  initial begin
    {arst_n, wr, rd, ack, ack_d, ack_en, rv, rl, addr, wdata, rdt, acc} = '0;
    src = 24'ha1b2c3;
    rs = 8'h5d;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    drd(8'hc1);
    chk(v, 32'h00);
    dwr(8'h4c, 8'h00);
    drd(8'h4c);
    chk(v, 32'h03);
    dwr(8'h4c, 8'h02);
    drd(8'h4c);
    chk(v, 32'h02);
    drd(8'h40);
    chk(v, 32'h00);
    rdr(8'h20);
    chk(v, 32'h00);
    $display("test config done");
    txb(9'h011);
    txb(9'h122);
    wtx(1);
    chk({tq[0], tq[1]}, 32'h1122);
    chk({bc, dst}, 32'h1ffffff);
    $display("test transparent done");
    dwr(8'hc1, 8'h06);
    wrr(`RHA_REG_DEST, 32'h123456);
    wrr(`RHA_REG_MASK, 32'h4);
    tq.delete();
    tn = 0;
    txb(9'h15a);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    if (irq !== 1'b1) hang();
    chk(tn, 2);
    chk({tq[0], tq[1]}, 32'h5a5a);
    chk({bc, dst}, 32'h0123456);
    rdr(`RHA_REG_STAT);
    chk(v[2:1], 2'b10);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rdr(`RHA_REG_STAT);
    chk(v[3:0], 4'h0);
    $display("test send fail done");
    ack_en = 1'b1;
    acc = '0;
    tn = 0;
    txb(9'h15a);
    for (int i = 0; i < 400 && acc[1] !== 1'b1; i++) rdr(`RHA_REG_STAT);
    if (acc[1] !== 1'b1) hang();
    chk({acc[2:1], irq}, 3'b010);
    chk(tn, 1);
    $display("test resubmit done");
    ack_en = 1'b0;
    wrr(`RHA_REG_DEST, 32'hffffff);
    acc = '0;
    tn = 0;
    txb(9'h133);
    wtx(1);
    repeat (40) @(posedge clk);
    rdr(`RHA_REG_STAT);
    chk({tn[1:0], bc, acc[2:1]}, 5'b01100);
    $display("test broadcast done");
    fork
      rfrx(2);
      rxget(2);
    join
    chk(rq[0], 9'h040);
    chk(rq[1], 9'h141);
    $display("test rx plain done");
    dwr(8'hc1, 8'h07);
    drd(8'hc1);
    chk(v, 32'h07);
    fork
      rfrx(2);
      rxget(7);
    join
    for (int i = 0; i < 7; i++) chk(rq[i], {i == 6, ex[i]});
    $display("test rx framed done");
    stop_test();
  end
endmodule
`default_nettype wire
